// >>> rtl/dac_cmd_pkg.sv
// constants shared by the dual dac command and register logic
// assumes a 40 MHz reference clock and a two-wire master clocking the link
package dac_cmd_pkg;

  // command byte layout
  localparam int CLASS_HI = 7;
  localparam int CLASS_LO = 6;
  localparam int SEL_HI = 5;
  localparam int SEL_LO = 4;
  localparam int REGSEL_HI = 3;
  localparam int REGSEL_LO = 0;

  // command classes in the two top bits
  localparam logic [1:0] CLASS_WRITE = 2'h0;
  localparam logic [1:0] CLASS_READ = 2'h2;

  // stored/volatile select pair
  localparam logic [1:0] SEL_XFER = 2'h0;
  localparam logic [1:0] SEL_VOL = 2'h1;
  localparam logic [1:0] SEL_STORED = 2'h2;
  localparam logic [1:0] SEL_BOTH = 2'h3;

  // register selector codes
  localparam logic [3:0] REGSEL_CH0 = 4'h0;
  localparam logic [3:0] REGSEL_CH1 = 4'h1;
  localparam logic [3:0] REGSEL_CTRL = 4'h4;
  localparam logic [3:0] REGSEL_ALL = 4'hf;

  // mute/power-down control byte fields
  localparam int CTRL_MUTE_CH1 = 5;
  localparam int CTRL_MUTE_CH0 = 4;
  localparam int CTRL_PD_CH1 = 1;
  localparam int CTRL_PD_CH0 = 0;

  // factory contents of the stored registers, muted output code and undefined read value
  localparam logic [7:0] STORED_CTRL_FACTORY = 8'h00;
  localparam logic [7:0] STORED_DATA_FACTORY = 8'h00;
  localparam logic [7:0] CODE_LOW_REF = 8'h00;
  localparam logic [7:0] READ_UNDEFINED = 8'h00;

  // slave address
  localparam logic [2:0] ADDR_FIXED = 3'h2;

  // serial framing
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_FIRST_AFTER_START = 4'h1;
  localparam logic [1:0] BYTE_ADDR = 2'h0;
  localparam logic [1:0] BYTE_CMD = 2'h1;
  localparam logic [1:0] BYTE_DATA = 2'h2;
  localparam logic [1:0] BYTE_BEYOND = 2'h3;

  // power-on initialisation interval
  localparam int INIT_TIME_US = 500;
  localparam int REF_CLK_MHZ = 40;
  localparam int INIT_CYCLES = INIT_TIME_US * REF_CLK_MHZ;

  // power-on sequencer states
  typedef enum logic [2:0] {
    ST_LOAD = 3'h1,
    ST_WAIT = 3'h2,
    ST_RUN = 3'h4
  } init_state_e;

endpackage : dac_cmd_pkg

// >>> rtl/dac_cmd_top.sv
// command decoding, register file and output control of a dual 8-bit dac
// assumes SCL clocks the link logic, SDA is open drain, RESET_N is power-on
module dac_cmd_top #(
  parameter int INIT_CYCLES = dac_cmd_pkg::INIT_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic MUTE_N,
  input wire logic [3:0] ADDR_STRAP,
  output logic [7:0] CH0_CODE,
  output logic [7:0] CH1_CODE,
  output logic CH0_MUTED,
  output logic CH1_MUTED,
  output logic CH0_HIZ,
  output logic CH1_HIZ,
  output logic INIT_BUSY
);

  localparam int CNT_W = $clog2(INIT_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // reference clock domain: pin synchronisers and frame detection

  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic mute_s1_q, mute_s2_q;
  logic [3:0] strap_s1_q, strap_s2_q;
  logic wr_s1_q, wr_s2_q, wr_s3_q;
  logic cmd_s1_q, cmd_s2_q, cmd_s3_q;
  logic link_run_q;
  logic wr_tgl_q, cmd_tgl_q;
  logic [7:0] rd_byte_q;
  logic start_seen, stop_seen, wr_event, cmd_event;

  // two flops per pin; third stage only for edge detection
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      mute_s1_q <= 1'b1;
      mute_s2_q <= 1'b1;
      strap_s1_q <= 4'h0;
      strap_s2_q <= 4'h0;
    end else begin
      scl_s1_q <= SCL;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= SDA_IN;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      mute_s1_q <= MUTE_N;
      mute_s2_q <= mute_s1_q;
      strap_s1_q <= ADDR_STRAP;
      strap_s2_q <= strap_s1_q;
    end
  end

  // event toggles from the link domain
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_s1_q <= 1'b0;
      wr_s2_q <= 1'b0;
      wr_s3_q <= 1'b0;
      cmd_s1_q <= 1'b0;
      cmd_s2_q <= 1'b0;
      cmd_s3_q <= 1'b0;
    end else begin
      wr_s1_q <= wr_tgl_q;
      wr_s2_q <= wr_s1_q;
      wr_s3_q <= wr_s2_q;
      cmd_s1_q <= cmd_tgl_q;
      cmd_s2_q <= cmd_s1_q;
      cmd_s3_q <= cmd_s2_q;
    end
  end

  assign start_seen = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  assign stop_seen = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  assign wr_event = wr_s2_q ^ wr_s3_q;
  assign cmd_event = cmd_s2_q ^ cmd_s3_q;

  // link logic held in reset between stop and start; the master clock stands
  // high then, so release lands well before the first falling edge
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      link_run_q <= 1'b0;
    end else if (start_seen) begin
      link_run_q <= 1'b1;
    end else if (stop_seen) begin
      link_run_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain on the serial clock

  logic [3:0] bit_cnt_q;
  logic [1:0] byte_idx_q;
  logic [7:0] shift_q;
  logic [7:0] cmd_q;
  logic [7:0] data_q;
  logic [7:0] tx_q;
  logic addr_hit_q, rw_q, sda_pos_q, restart_q;
  logic byte_done;
  logic [7:0] rx_byte;

  assign byte_done = ~restart_q & (bit_cnt_q == dac_cmd_pkg::BIT_LAST);
  assign rx_byte = {shift_q[6:0], SDA_IN};

  // bit and byte position within the frame
  always_ff @(posedge SCL or negedge link_run_q) begin
    if (!link_run_q) begin
      bit_cnt_q <= 4'h0;
      byte_idx_q <= dac_cmd_pkg::BYTE_ADDR;
    end else if (restart_q) begin
      bit_cnt_q <= dac_cmd_pkg::BIT_FIRST_AFTER_START;
      byte_idx_q <= dac_cmd_pkg::BYTE_ADDR;
    end else if (bit_cnt_q == dac_cmd_pkg::BIT_ACK) begin
      bit_cnt_q <= 4'h0;
      if (byte_idx_q != dac_cmd_pkg::BYTE_BEYOND) begin
        byte_idx_q <= byte_idx_q + 2'h1;
      end
    end else begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // receive shifter and level of SDA seen at the rising edge
  always_ff @(posedge SCL or negedge link_run_q) begin
    if (!link_run_q) begin
      shift_q <= 8'h00;
      sda_pos_q <= 1'b0;
    end else begin
      sda_pos_q <= SDA_IN;
      if (restart_q || bit_cnt_q != dac_cmd_pkg::BIT_ACK) begin
        shift_q <= rx_byte;
      end
    end
  end

  // address match and direction
  always_ff @(posedge SCL or negedge link_run_q) begin
    if (!link_run_q) begin
      addr_hit_q <= 1'b0;
      rw_q <= 1'b0;
    end else if (restart_q) begin
      addr_hit_q <= 1'b0;
    end else if (byte_done && byte_idx_q == dac_cmd_pkg::BYTE_ADDR) begin
      addr_hit_q <= (rx_byte[7:5] == dac_cmd_pkg::ADDR_FIXED)
                    && (rx_byte[4:1] == strap_s2_q);
      rw_q <= rx_byte[0];
    end
  end

  // command and data capture; commit toggles on the 26th rising edge
  // power-on reset only: clearing the toggles at stop would fake a commit
  always_ff @(posedge SCL or negedge RESET_N) begin
    if (!RESET_N) begin
      cmd_q <= 8'h00;
      data_q <= 8'h00;
      wr_tgl_q <= 1'b0;
      cmd_tgl_q <= 1'b0;
    end else if (byte_done && addr_hit_q && !rw_q) begin
      if (byte_idx_q == dac_cmd_pkg::BYTE_CMD) begin
        cmd_q <= rx_byte;
        cmd_tgl_q <= ~cmd_tgl_q;
      end else if (byte_idx_q == dac_cmd_pkg::BYTE_DATA) begin
        data_q <= rx_byte;
        wr_tgl_q <= ~wr_tgl_q;
      end
    end
  end

  // falling edge: repeated start detection, ack and read data drive
  // rd_byte_q is settled many link clocks before it is loaded here
  always_ff @(negedge SCL or negedge link_run_q) begin
    if (!link_run_q) begin
      restart_q <= 1'b0;
      SDA_OE <= 1'b0;
      SDA_OUT <= 1'b0;
      tx_q <= 8'h00;
    end else begin
      restart_q <= sda_pos_q & ~SDA_IN;
      SDA_OUT <= 1'b0;
      if (sda_pos_q && !SDA_IN) begin
        SDA_OE <= 1'b0;
      end else if (bit_cnt_q == dac_cmd_pkg::BIT_ACK) begin
        SDA_OE <= addr_hit_q && (byte_idx_q == dac_cmd_pkg::BYTE_ADDR || !rw_q);
        if (byte_idx_q == dac_cmd_pkg::BYTE_ADDR) begin
          tx_q <= rd_byte_q;
        end
      end else if (addr_hit_q && rw_q && byte_idx_q == dac_cmd_pkg::BYTE_CMD) begin
        SDA_OE <= ~tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end else begin
        SDA_OE <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file and command decode, reference clock domain

  // stored copies model nonvolatile cells: no reset, factory contents
  logic [7:0] stored_channel_data_q [2] = '{2{dac_cmd_pkg::STORED_DATA_FACTORY}};
  logic [7:0] stored_mute_powerdown_control_q = dac_cmd_pkg::STORED_CTRL_FACTORY;
  logic [7:0] volatile_channel_data_q [2];
  logic [7:0] volatile_mute_powerdown_control_q;
  dac_cmd_pkg::init_state_e state_q;
  logic [CNT_W-1:0] init_cnt_q;

  logic [1:0] command_class, stored_select_bit;
  logic [3:0] register_selector;
  logic cmd_ok;

  assign command_class = cmd_q[dac_cmd_pkg::CLASS_HI:dac_cmd_pkg::CLASS_LO];
  assign stored_select_bit = cmd_q[dac_cmd_pkg::SEL_HI:dac_cmd_pkg::SEL_LO];
  assign register_selector = cmd_q[dac_cmd_pkg::REGSEL_HI:dac_cmd_pkg::REGSEL_LO];
  // unknown classes and selectors fall out here and change nothing
  assign cmd_ok = (command_class == dac_cmd_pkg::CLASS_WRITE)
                  && (register_selector == dac_cmd_pkg::REGSEL_CH0
                      || register_selector == dac_cmd_pkg::REGSEL_CH1
                      || register_selector == dac_cmd_pkg::REGSEL_CTRL
                      || (register_selector == dac_cmd_pkg::REGSEL_ALL
                          && stored_select_bit == dac_cmd_pkg::SEL_VOL));

  // power-on sequencer: load, hold muted, then run
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= dac_cmd_pkg::ST_LOAD;
      init_cnt_q <= '0;
    end else begin
      unique case (state_q)
        dac_cmd_pkg::ST_LOAD: begin
          state_q <= dac_cmd_pkg::ST_WAIT;
        end
        dac_cmd_pkg::ST_WAIT: begin
          init_cnt_q <= init_cnt_q + 1'b1;
          if (init_cnt_q == CNT_W'(INIT_CYCLES - 1)) begin
            state_q <= dac_cmd_pkg::ST_RUN;
          end
        end
        dac_cmd_pkg::ST_RUN: begin
          state_q <= dac_cmd_pkg::ST_RUN;
        end
        default: begin
          state_q <= dac_cmd_pkg::ST_LOAD;
        end
      endcase
    end
  end

  // volatile registers: loaded at power-on, then written by commands
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      volatile_channel_data_q[0] <= dac_cmd_pkg::STORED_DATA_FACTORY;
      volatile_channel_data_q[1] <= dac_cmd_pkg::STORED_DATA_FACTORY;
      volatile_mute_powerdown_control_q <= dac_cmd_pkg::STORED_CTRL_FACTORY;
    end else if (state_q == dac_cmd_pkg::ST_LOAD) begin
      volatile_channel_data_q <= stored_channel_data_q;
      volatile_mute_powerdown_control_q <= stored_mute_powerdown_control_q;
    end else if (wr_event && cmd_ok) begin
      for (int i = 0; i < 2; i++) begin
        if (register_selector == 4'(i) || register_selector == dac_cmd_pkg::REGSEL_ALL) begin
          if (stored_select_bit == dac_cmd_pkg::SEL_XFER) begin
            volatile_channel_data_q[i] <= stored_channel_data_q[i];
          end else if (stored_select_bit[0]) begin
            volatile_channel_data_q[i] <= data_q;
          end
        end
      end
      if (register_selector == dac_cmd_pkg::REGSEL_CTRL) begin
        if (stored_select_bit == dac_cmd_pkg::SEL_XFER) begin
          volatile_mute_powerdown_control_q <= stored_mute_powerdown_control_q;
        end else if (stored_select_bit[0]) begin
          volatile_mute_powerdown_control_q <= data_q;
        end
      end
    end
  end

  // stored registers: only written by commands, never by reset
  always_ff @(posedge REF_CLK) begin
    if (wr_event && cmd_ok && stored_select_bit[1]) begin
      for (int i = 0; i < 2; i++) begin
        if (register_selector == 4'(i)) begin
          stored_channel_data_q[i] <= data_q;
        end
      end
      if (register_selector == dac_cmd_pkg::REGSEL_CTRL) begin
        stored_mute_powerdown_control_q <= data_q;
      end
    end
  end

  // read byte prepared once the command byte lands
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_byte_q <= dac_cmd_pkg::READ_UNDEFINED;
    end else if (cmd_event) begin
      rd_byte_q <= dac_cmd_pkg::READ_UNDEFINED;
      if (command_class == dac_cmd_pkg::CLASS_READ) begin
        if (stored_select_bit == dac_cmd_pkg::SEL_VOL) begin
          if (register_selector == dac_cmd_pkg::REGSEL_CH0
              || register_selector == dac_cmd_pkg::REGSEL_CH1) begin
            rd_byte_q <= volatile_channel_data_q[register_selector[0]];
          end else if (register_selector == dac_cmd_pkg::REGSEL_CTRL) begin
            rd_byte_q <= volatile_mute_powerdown_control_q;
          end
        end else if (stored_select_bit == dac_cmd_pkg::SEL_STORED) begin
          if (register_selector == dac_cmd_pkg::REGSEL_CH0
              || register_selector == dac_cmd_pkg::REGSEL_CH1) begin
            rd_byte_q <= stored_channel_data_q[register_selector[0]];
          end else if (register_selector == dac_cmd_pkg::REGSEL_CTRL) begin
            rd_byte_q <= stored_mute_powerdown_control_q;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel outputs

  logic busy, pin_mute, pd0, pd1, mute0, mute1;

  assign busy = (state_q != dac_cmd_pkg::ST_RUN);
  assign pin_mute = ~mute_s2_q;
  assign pd0 = volatile_mute_powerdown_control_q[dac_cmd_pkg::CTRL_PD_CH0];
  assign pd1 = volatile_mute_powerdown_control_q[dac_cmd_pkg::CTRL_PD_CH1];
  assign mute0 = busy | pin_mute
                 | volatile_mute_powerdown_control_q[dac_cmd_pkg::CTRL_MUTE_CH0];
  assign mute1 = busy | pin_mute
                 | volatile_mute_powerdown_control_q[dac_cmd_pkg::CTRL_MUTE_CH1];

  // muted code is the low reference; data stays in the volatile register
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CH0_CODE <= dac_cmd_pkg::CODE_LOW_REF;
      CH1_CODE <= dac_cmd_pkg::CODE_LOW_REF;
      CH0_MUTED <= 1'b1;
      CH1_MUTED <= 1'b1;
      CH0_HIZ <= 1'b0;
      CH1_HIZ <= 1'b0;
      INIT_BUSY <= 1'b1;
    end else begin
      CH0_HIZ <= pd0;
      CH1_HIZ <= pd1;
      CH0_MUTED <= mute0 & ~pd0;
      CH1_MUTED <= mute1 & ~pd1;
      CH0_CODE <= (mute0 | pd0) ? dac_cmd_pkg::CODE_LOW_REF
                                : volatile_channel_data_q[0];
      CH1_CODE <= (mute1 | pd1) ? dac_cmd_pkg::CODE_LOW_REF
                                : volatile_channel_data_q[1];
      INIT_BUSY <= busy;
    end
  end

endmodule : dac_cmd_top

// >>> tb/dac_cmd_assertions.sv
// concurrent checks on the ports of the dual dac command block
// assumes binding into dac_cmd_top, all checks on the reference clock
module dac_cmd_assertions #(
  parameter int INIT_CYCLES = 20
) (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic MUTE_N,
  input wire logic [3:0] ADDR_STRAP,
  input wire logic [7:0] CH0_CODE,
  input wire logic [7:0] CH1_CODE,
  input wire logic CH0_MUTED,
  input wire logic CH1_MUTED,
  input wire logic CH0_HIZ,
  input wire logic CH1_HIZ,
  input wire logic INIT_BUSY
);
  logic [31:0] busy_cnt_q;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  // cycles spent initialising since the last reset
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_cnt_q <= 32'h0;
    end else if (INIT_BUSY) begin
      busy_cnt_q <= busy_cnt_q + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  a_ch0_hiz_wins: assert property (CH0_HIZ |-> !CH0_MUTED && CH0_CODE == 8'h00)
    else $error("ch0 powered down but not quiet");
  a_ch1_hiz_wins: assert property (CH1_HIZ |-> !CH1_MUTED && CH1_CODE == 8'h00)
    else $error("ch1 powered down but not quiet");
  a_ch0_mute_low: assert property (CH0_MUTED |-> CH0_CODE == dac_cmd_pkg::CODE_LOW_REF)
    else $error("ch0 muted with nonzero code");
  a_ch1_mute_low: assert property (CH1_MUTED |-> CH1_CODE == dac_cmd_pkg::CODE_LOW_REF)
    else $error("ch1 muted with nonzero code");
  a_init_keeps_mute: assert property (INIT_BUSY |-> (CH0_MUTED || CH0_HIZ) && (CH1_MUTED || CH1_HIZ))
    else $error("output live during initialisation");
  // two sync flops plus the output flop fit in four low samples
  a_pin_mutes_both: assert property (!MUTE_N [*4] |-> (CH0_MUTED || CH0_HIZ) && (CH1_MUTED || CH1_HIZ))
    else $error("mute pin not obeyed");
  a_init_length: assert property ($fell(INIT_BUSY) |-> busy_cnt_q >= INIT_CYCLES && busy_cnt_q <= INIT_CYCLES + 3)
    else $error("initialisation interval wrong length");
  a_busy_once: assert property (!INIT_BUSY |=> !INIT_BUSY)
    else $error("initialisation restarted without reset");
  // a quiet link must not move the channel codes or CH0_HIZ
  a_idle_holds: assert property ((SCL && MUTE_N && !INIT_BUSY) [*8] |=> $stable(CH0_CODE) && $stable(CH1_CODE) && $stable(CH0_HIZ))
    else $error("outputs changed on an idle link");

  c_init_done: cover property ($fell(INIT_BUSY));
  c_power_down: cover property ($rose(CH1_HIZ));
  c_pin_mute: cover property (!MUTE_N [*4]);
  c_ack: cover property ($rose(SDA_OE));
endmodule : dac_cmd_assertions

bind dac_cmd_top dac_cmd_assertions #(.INIT_CYCLES(INIT_CYCLES)) dac_cmd_assertions_inst (
  .REF_CLK(REF_CLK), .RESET_N(RESET_N), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .MUTE_N(MUTE_N), .ADDR_STRAP(ADDR_STRAP), .CH0_CODE(CH0_CODE),
  .CH1_CODE(CH1_CODE), .CH0_MUTED(CH0_MUTED), .CH1_MUTED(CH1_MUTED), .CH0_HIZ(CH0_HIZ),
  .CH1_HIZ(CH1_HIZ), .INIT_BUSY(INIT_BUSY));

// >>> tb/tb.sv
// self-checking bench for the dual dac command block
// assumes the master model drives the link and a pull-up on sda
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int INIT_N = 20;
  logic ref_clk, reset_n, mute_n, ack, sda_out, sda_oe, busy, m0, m1, z0, z1;
  logic [3:0] strap;
  logic [6:0] dev;
  wire scl, sda_low, sda;
  logic [7:0] c0, c1, obs, exp_v, v0, v1, v2, v3, v5, v6, v7;
  logic [7:0] exp_q[$];
  logic [7:0] bad[5] = '{8'h3f, 8'h0f, 8'h50, 8'h12, 8'hd0};
  event seen_ev;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed;

  // open drain wire: low when either party pulls
  assign sda = !(sda_low || (sda_oe && !sda_out));

  dac_cmd_top #(.INIT_CYCLES(INIT_N)) dac_cmd_top_inst (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .MUTE_N(mute_n), .ADDR_STRAP(strap), .CH0_CODE(c0), .CH1_CODE(c1),
    .CH0_MUTED(m0), .CH1_MUTED(m1), .CH0_HIZ(z0), .CH1_HIZ(z1), .INIT_BUSY(busy));
  twi_master_model twi_master_model_inst (.scl(scl), .sda_low(sda_low), .sda(sda));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = !ref_clk;
  end

  // compares each seen result with the oldest note
  always @(seen_ev) begin
    exp_v = exp_q.pop_front();
    n_compared++;
    if (exp_v !== obs) begin
      errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp_v, obs);
    end
  end

  // hang guard, well above the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  function automatic logic [7:0] wc(input logic [1:0] s, input logic [3:0] r);
    return {dac_cmd_pkg::CLASS_WRITE, s, r};
  endfunction : wc

  function automatic logic [7:0] rc(input logic [1:0] s, input logic [3:0] r);
    return {dac_cmd_pkg::CLASS_READ, s, r};
  endfunction : rc

  task automatic chk(input logic [7:0] e, input logic [7:0] v);
    exp_q.push_back(e);
    obs = v;
    ->seen_ev;
    #1;
  endtask : chk

  // commit plus crossing plus output flop fit in ten cycles
  task automatic w(input logic [7:0] c, input logic [7:0] d);
    twi_master_model_inst.wr(dev, c, d, 1'b1, ack);
    chk(8'h01, {7'h0, ack});
    repeat (10) @(negedge ref_clk);
  endtask : w

  task automatic r(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] v;
    twi_master_model_inst.rd(dev, c, v);
    chk(e, v);
  endtask : r

  task automatic outs(input logic [7:0] e0, input logic [7:0] e1);
    chk(e0, c0);
    chk(e1, c1);
  endtask : outs

  // order: mute0 mute1 hiz0 hiz1
  task automatic flags(input logic [3:0] e);
    chk({4'h0, e}, {4'h0, m0, m1, z0, z1});
  endtask : flags

  task automatic power_cycle;
    reset_n = 1'b0;
    repeat (20) @(negedge ref_clk);
    reset_n = 1'b1;
    @(negedge ref_clk);
    chk(8'h01, {7'h0, busy});
    repeat (INIT_N + 6) @(negedge ref_clk);
    chk(8'h00, {7'h0, busy});
  endtask : power_cycle

  initial begin
    reset_n = 1'b0;
    mute_n = 1'b1;
    strap = 4'h0;
    seed = $urandom(32'h5bc2);
    @(negedge ref_clk);
    strap = 4'($urandom);
    dev = {dac_cmd_pkg::ADDR_FIXED, strap};
    power_cycle();
    outs(8'h00, 8'h00);
    flags(4'h0);
    $display("test power_on done");
    v0 = 8'($urandom);
    v1 = 8'($urandom);
    w(wc(2'h1, 4'h0), v0);
    w(wc(2'h3, 4'h1), v1);
    outs(v0, v1);
    r(rc(2'h1, 4'h0), v0);
    r(rc(2'h2, 4'h1), v1);
    r(rc(2'h2, 4'h0), 8'h00);
    r(rc(2'h1, 4'hf), dac_cmd_pkg::READ_UNDEFINED);
    v2 = v0 ^ 8'h5a;
    w(wc(2'h2, 4'h0), v2);
    outs(v0, v1);
    w(wc(2'h0, 4'h0), ~v2);
    outs(v2, v1);
    $display("test data_path done");
    v3 = 8'($urandom);
    w(wc(2'h1, 4'hf), v3);
    outs(v3, v3);
    for (int i = 0; i < 5; i++) begin
      w(bad[i], ~v3);
      outs(v3, v3);
    end
    twi_master_model_inst.wr(dev, wc(2'h1, 4'h0), 8'h00, 1'b0, ack);
    repeat (10) @(negedge ref_clk);
    outs(v3, v3);
    twi_master_model_inst.wr(dev ^ 7'h01, wc(2'h1, 4'h0), 8'h00, 1'b1, ack);
    chk(8'h00, {7'h0, ack});
    repeat (10) @(negedge ref_clk);
    outs(v3, v3);
    $display("test refusals done");
    w(wc(2'h1, 4'h4), 8'h10);
    flags(4'h8);
    outs(8'h00, v3);
    v5 = 8'($urandom);
    w(wc(2'h1, 4'h0), v5);
    outs(8'h00, v3);
    r(rc(2'h1, 4'h0), v5);
    r(rc(2'h1, 4'h4), 8'h10);
    w(wc(2'h1, 4'h4), 8'hee);
    flags(4'h1);
    outs(v5, 8'h00);
    w(wc(2'h1, 4'h4), 8'h01);
    flags(4'h2);
    w(wc(2'h1, 4'h4), 8'h00);
    $display("test mute_power_down done");
    mute_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    flags(4'hc);
    v6 = 8'($urandom);
    w(wc(2'h1, 4'h1), v6);
    outs(8'h00, 8'h00);
    mute_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    outs(v5, v6);
    $display("test mute_pin done");
    v7 = 8'($urandom);
    w(wc(2'h2, 4'h4), 8'h20);
    w(wc(2'h2, 4'h1), v7);
    power_cycle();
    flags(4'h4);
    outs(v2, 8'h00);
    r(rc(2'h1, 4'h1), v7);
    w(wc(2'h3, 4'h4), 8'h00);
    flags(4'h0);
    r(rc(2'h2, 4'h4), 8'h00);
    w(wc(2'h2, 4'h4), 8'h01);
    w(wc(2'h0, 4'h4), 8'hff);
    flags(4'h2);
    $display("test power_cycle done");
    print_verdict();
  end
endmodule : tb

// >>> tb/twi_master_model.sv
// two-wire bus master model for the dac's serial link
// assumes the bench resolves sda as open drain with a pull-up
module twi_master_model #(
  parameter int HALF = 120
) (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // bus idles high, clock still outside frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // data moves while scl is low and is sampled at the rising edge
  task automatic bit_io(input logic b, output logic s);
    #(HALF / 2) sda_low = !b;
    #(HALF / 2) scl = 1'b1;
    s = sda;
    #(HALF) scl = 1'b0;
  endtask : bit_io

  // long high phase so the reference-clock side sees the condition
  task automatic start_c;
    #(HALF / 2) sda_low = 1'b0;
    #(HALF / 2) scl = 1'b1;
    #200 sda_low = 1'b1;
    #200 scl = 1'b0;
  endtask : start_c

  task automatic stop_c;
    #(HALF / 2) sda_low = 1'b1;
    #(HALF / 2) scl = 1'b1;
    #200 sda_low = 1'b0;
    #400;
  endtask : stop_c

  task automatic byte_o(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask : byte_o

  // one byte in, answered with a not-acknowledge
  task automatic byte_i(output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      v[i] = s;
    end
    bit_io(1'b1, s);
  endtask : byte_i

  // full low stops the frame after the command byte
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                    input logic full, output logic ack);
    logic k;
    start_c();
    byte_o({a, 1'b0}, ack);
    byte_o(c, k);
    if (full) begin
      byte_o(d, k);
    end
    stop_c();
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] v);
    logic k;
    start_c();
    byte_o({a, 1'b0}, k);
    byte_o(c, k);
    start_c();
    byte_o({a, 1'b1}, k);
    byte_i(v);
    stop_c();
  endtask : rd
endmodule : twi_master_model
